// ===== rtl/opmode_pkg.sv
package opmode_pkg;

  localparam int GPR_W = 32;
  localparam int CTX_W = 32;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic FLAG_CLR = 1'b0;

  typedef enum logic [1:0] {
    MODE_REAL,
    MODE_PROT,
    MODE_SMM
  } mode_e;

  typedef enum logic [1:0] {
    VIEW_LOW_BYTE,
    VIEW_HIGH_BYTE,
    VIEW_HALF,
    VIEW_FULL
  } view_e;

  // Narrow views are zero extended so the consumer sees one fixed width.
  function automatic logic [GPR_W-1:0] reg_view(
    input logic [GPR_W-1:0] val,
    input view_e sel
  );
    logic [GPR_W-1:0] res;
    res = '0;
    case (sel)
      VIEW_LOW_BYTE: res[BYTE_W-1:0] = val[BYTE_W-1:0];
      VIEW_HIGH_BYTE: res[BYTE_W-1:0] = val[2*BYTE_W-1:BYTE_W];
      VIEW_HALF: res[HALF_W-1:0] = val[HALF_W-1:0];
      default: res = val;
    endcase
    return res;
  endfunction

endpackage

// ===== rtl/ctx_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ctx_if #(
  parameter int W = 8
);
  logic wr;
  logic [W-1:0] wdata;
  logic rd;
  logic [W-1:0] rdata;

  modport owner(output wr, output wdata, output rd, input rdata);
  modport store(input wr, input wdata, input rd, output rdata);
endinterface

`default_nettype wire

// ===== rtl/ctx_store.sv
`timescale 1ns/1ps
`default_nettype none

module ctx_store #(
  parameter int W = 8
)(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  ctx_if.store bus
);

  typedef struct packed {
    logic [W-1:0] mem;
    logic [W-1:0] rdata;
  } store_s;

  store_s st_r;
  store_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (bus.wr)
    begin
      st_nxt.mem = bus.wdata;
    end
    if (bus.rd)
    begin
      st_nxt.rdata = st_r.mem;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign bus.rdata = st_r.rdata;

endmodule

`default_nettype wire

// ===== rtl/cpu_operating_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reset or power-up always leaves the core in real-address mode.
// - A falling pin edge or controller message requests system management mode.
// - Entry saves the context and selects the separate address space.
// - Return restores exactly the saved mode, attribute and context.
// - Protected mode is native and enables every instruction and feature.
// - Legacy emulation is a per-task attribute within protected mode.
// - Real mode software may enter protected or system management mode.
// - Each 32-bit register reads also as low byte, high byte or halfword.
// - Mode gates feature access; the register environment stays the same.
module cpu_operating_mode_control #(
  parameter int GPR_W = opmode_pkg::GPR_W,
  parameter int CTX_W = opmode_pkg::CTX_W
)(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_sys_mgmt_irq_n,
  input wire logic i_adv_irq_ctrl_msg,
  input wire logic i_insn_boundary,
  input wire logic i_sw_enter_prot,
  input wire logic i_sw_leave_prot,
  input wire logic i_sw_sys_mgmt,
  input wire logic i_sw_resume,
  input wire logic i_task_emul_wr,
  input wire logic i_task_emul_val,
  input wire logic [CTX_W-1:0] i_ctx,
  input wire logic [GPR_W-1:0] i_gpr,
  input wire opmode_pkg::view_e i_gpr_view,
  output opmode_pkg::mode_e o_mode,
  output logic o_all_features,
  output logic o_emul_active,
  output logic o_sys_mgmt_space,
  output logic o_ctx_saved,
  output logic o_ctx_restored,
  output logic [CTX_W-1:0] o_restored_ctx,
  output logic [GPR_W-1:0] o_gpr_data
);

  localparam int SAVE_W = CTX_W + 3;

  typedef enum logic [1:0] {
    ST_REAL,
    ST_PROT,
    ST_SMM,
    ST_RESUME
  } state_e;

  typedef struct packed {
    state_e state;
    logic sync1;
    logic sync2;
    logic sync3;
    logic pend;
    logic emul;
    logic saved;
    logic restored;
    logic [CTX_W-1:0] ctx;
    logic [GPR_W-1:0] gpr;
  } ctl_s;

  ctl_s st_r;
  ctl_s st_nxt;
  ctx_if #(.W(SAVE_W)) save_bus ();

  logic req_new;
  logic take;
  opmode_pkg::mode_e saved_mode;

  ctx_store #(.W(SAVE_W)) u_store (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .bus(save_bus.store)
  );

  ////////////////////////////////////////////////////////////////////////////

  // The pin is taken on its falling edge so a level held low by the platform
  // cannot retrigger entry straight after resume.
  assign req_new = ((!st_r.sync2 && st_r.sync3) || i_adv_irq_ctrl_msg ||
    i_sw_sys_mgmt) &&
    (st_r.state == ST_REAL || st_r.state == ST_PROT);
  assign take = (st_r.pend || req_new) && i_insn_boundary;
  assign saved_mode = opmode_pkg::mode_e'(save_bus.rdata[SAVE_W-1 -: 2]);

  assign save_bus.wr = take;
  assign save_bus.wdata = {o_mode, st_r.emul, i_ctx};
  assign save_bus.rd = (st_r.state == ST_SMM) && i_sw_resume;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sync1 = i_sys_mgmt_irq_n;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    st_nxt.saved = take;
    st_nxt.restored = 1'b0;
    st_nxt.gpr = opmode_pkg::reg_view(i_gpr, i_gpr_view);
    // The taking cycle clears the flag, even with a new request in that cycle.
    st_nxt.pend = (st_r.pend || req_new) && !take;
    case (st_r.state)
      ST_REAL:
      begin
        st_nxt.emul = opmode_pkg::FLAG_CLR;
        if (take)
        begin
          st_nxt.state = ST_SMM;
        end
        else if (i_sw_enter_prot)
        begin
          st_nxt.state = ST_PROT;
        end
      end
      ST_PROT:
      begin
        if (take)
        begin
          st_nxt.state = ST_SMM;
        end
        else if (i_sw_leave_prot)
        begin
          st_nxt.state = ST_REAL;
          st_nxt.emul = opmode_pkg::FLAG_CLR;
        end
        else if (i_task_emul_wr)
        begin
          st_nxt.emul = i_task_emul_val;
        end
      end
      ST_SMM:
      begin
        st_nxt.pend = opmode_pkg::FLAG_CLR;
        if (i_sw_resume)
        begin
          st_nxt.state = ST_RESUME;
        end
      end
      ST_RESUME:
      begin
        st_nxt.pend = opmode_pkg::FLAG_CLR;
        st_nxt.restored = 1'b1;
        st_nxt.ctx = save_bus.rdata[CTX_W-1:0];
        st_nxt.emul = save_bus.rdata[CTX_W];
        st_nxt.state = (saved_mode == opmode_pkg::MODE_PROT) ? ST_PROT :
          ST_REAL;
      end
      default:
      begin
        st_nxt.state = ST_REAL;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      st_r <= '0;
      st_r.state <= ST_REAL;
      st_r.sync1 <= opmode_pkg::PIN_IDLE;
      st_r.sync2 <= opmode_pkg::PIN_IDLE;
      st_r.sync3 <= opmode_pkg::PIN_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    case (st_r.state)
      ST_PROT: o_mode = opmode_pkg::MODE_PROT;
      ST_SMM: o_mode = opmode_pkg::MODE_SMM;
      ST_RESUME: o_mode = opmode_pkg::MODE_SMM;
      default: o_mode = opmode_pkg::MODE_REAL;
    endcase
  end

  // The feature gate, emulation flag and space select change with mode; registers are shared.
  assign o_all_features = (st_r.state == ST_PROT);
  assign o_emul_active = st_r.emul && (st_r.state == ST_PROT);
  assign o_sys_mgmt_space = (o_mode == opmode_pkg::MODE_SMM);
  assign o_ctx_saved = st_r.saved;
  assign o_ctx_restored = st_r.restored;
  assign o_restored_ctx = st_r.ctx;
  assign o_gpr_data = st_r.gpr;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  reset_real_a: assert property (
    $rose(i_nrst) |-> o_mode == opmode_pkg::MODE_REAL)
    else $error("Mode after reset is not real-address.");
  msg_entry_a: assert property (
    i_adv_irq_ctrl_msg && i_insn_boundary &&
    o_mode != opmode_pkg::MODE_SMM |=> o_mode == opmode_pkg::MODE_SMM)
    else $error("Controller message did not enter management mode.");
  save_space_a: assert property (
    o_ctx_saved |-> o_sys_mgmt_space &&
    $past(o_mode) != opmode_pkg::MODE_SMM)
    else $error("Context save without entry to the separate space.");
  resume_mode_a: assert property (
    o_mode == opmode_pkg::MODE_PROT && i_insn_boundary &&
    i_sw_sys_mgmt ##1 i_sw_resume |=> ##1 o_mode == opmode_pkg::MODE_PROT)
    else $error("Resume did not restore protected mode.");
  // The context was sampled at the taking edge, one before the save pulse.
  resume_ctx_a: assert property (
    o_ctx_saved ##0 (i_sw_resume && !o_ctx_restored) |->
    ##2 o_ctx_restored && o_restored_ctx == $past(i_ctx, 3))
    else $error("Restored context differs from saved context.");
  prot_feat_a: assert property (
    o_all_features == (o_mode == opmode_pkg::MODE_PROT))
    else $error("Feature gate disagrees with mode.");
  emul_prot_a: assert property (
    o_emul_active |-> o_mode == opmode_pkg::MODE_PROT)
    else $error("Emulation attribute active outside protected mode.");
  real_prot_a: assert property (
    o_mode == opmode_pkg::MODE_REAL && i_sw_enter_prot &&
    !take |=> o_mode == opmode_pkg::MODE_PROT)
    else $error("Real mode did not move to protected mode.");
  view_byte_a: assert property (
    i_gpr_view == opmode_pkg::VIEW_HIGH_BYTE |=>
    o_gpr_data == {24'h00_0000, $past(i_gpr[15:8])})
    else $error("High byte view is wrong.");
  boundary_a: assert property (
    !i_insn_boundary |=> !o_ctx_saved)
    else $error("Entry taken off an instruction boundary.");
  no_nest_a: assert property (
    o_mode == opmode_pkg::MODE_SMM |=> !o_ctx_saved)
    else $error("Nested management entry.");

  enter_pin_c: cover property (!st_r.sync2 && st_r.sync3 ##[1:20] o_ctx_saved);
  round_trip_c: cover property (o_ctx_saved ##[1:20] o_ctx_restored);
  emul_on_c: cover property (o_emul_active);

endmodule

`default_nettype wire

// ===== sim/irq_source.sv
`timescale 1ns/1ps
`default_nettype none

// The pin idles high and the controller message is a one-cycle pulse.
// Outputs move one falling edge after a request, which keeps them
// clear of the core's sampling edge.
module irq_source (
  input wire logic i_sys_clk,
  input wire logic i_pin_req,
  input wire logic i_msg_req,
  output var logic o_sys_mgmt_irq_n,
  output var logic o_adv_irq_ctrl_msg
);
  initial
  begin
    o_sys_mgmt_irq_n = 1'b1;
    o_adv_irq_ctrl_msg = 1'b0;
  end

  always @(negedge i_sys_clk)
  begin
    o_sys_mgmt_irq_n <= !i_pin_req;
    o_adv_irq_ctrl_msg <= i_msg_req;
  end
endmodule

`default_nettype wire

// ===== sim/tb_cpu_operating_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_operating_mode_control;
  // Strobes share one vector so a single task can pulse any of them.
  localparam int ENTER = 0, LEAVE = 1, SWM = 2, RESUME = 3, EWR = 4, MSG = 5;
  logic clk = 0, nrst = 0, pin_req = 0, bnd = 1, eval = 0;
  logic [5:0] pls = '0;
  logic [31:0] ctx = '0, gpr = '0;
  opmode_pkg::view_e view = opmode_pkg::VIEW_FULL;
  wire logic pin_n, msg;
  opmode_pkg::mode_e mode;
  logic feat, emul, space, saved, rest;
  logic [31:0] rctx, gdata;
  int errors = 0, checks = 0, cycles = 0;

  irq_source u_irq_source (.i_sys_clk(clk), .i_pin_req(pin_req),
    .i_msg_req(pls[MSG]), .o_sys_mgmt_irq_n(pin_n),
    .o_adv_irq_ctrl_msg(msg));

  cpu_operating_mode_control u_cpu_operating_mode_control (
    .i_sys_clk(clk), .i_nrst(nrst), .i_sys_mgmt_irq_n(pin_n),
    .i_adv_irq_ctrl_msg(msg), .i_insn_boundary(bnd),
    .i_sw_enter_prot(pls[ENTER]), .i_sw_leave_prot(pls[LEAVE]),
    .i_sw_sys_mgmt(pls[SWM]), .i_sw_resume(pls[RESUME]),
    .i_task_emul_wr(pls[EWR]),
    .i_task_emul_val(eval), .i_ctx(ctx), .i_gpr(gpr),
    .i_gpr_view(view), .o_mode(mode), .o_all_features(feat),
    .o_emul_active(emul), .o_sys_mgmt_space(space),
    .o_ctx_saved(saved), .o_ctx_restored(rest),
    .o_restored_ctx(rctx), .o_gpr_data(gdata));

  initial
  begin
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Views are checked in real and protected mode since the register environment holds.
  task automatic s_view();
    logic [31:0] exp [4] = '{32'h0000_0078, 32'h0000_0056,
                             32'h0000_5678, 32'h1234_5678};
    gpr <= 32'h1234_5678;
    for (int i = 0; i < 4; i++)
    begin
      view <= opmode_pkg::view_e'(i);
      cyc(1);
      chk(gdata, exp[i]);
    end
  endtask

  task automatic pulse(input int k);
    pls[k] <= 1'b1;
    cyc(1);
    pls[k] <= 1'b0;
  endtask

  // Entry answers in the cycle right after the taking edge, then must drop.
  task automatic chk_entry();
    chk(32'(mode), 32'(opmode_pkg::MODE_SMM));
    chk(32'({saved, space, feat, emul}), 32'h0000_000c);
    cyc(1);
    chk(32'(saved), 32'h0000_0000);
  endtask

  task automatic s_resume(input opmode_pkg::mode_e m, input logic e);
    pulse(RESUME);
    chk(32'(mode), 32'(opmode_pkg::MODE_SMM));
    cyc(1);
    chk(32'(mode), 32'(m));
    chk(32'({rest, emul, space}), 32'({1'b1, e, 1'b0}));
    chk(rctx, ctx);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(3);
    chk(32'({mode, feat, saved, rest}), 32'h0000_0000);
    chk(rctx, 32'h0000_0000);
    nrst <= 1;
    cyc(1);
    s_view();
    eval <= 1;
    pulse(EWR);
    cyc(1);
    chk(32'(emul), 32'h0000_0000);
    pulse(ENTER);
    chk(32'({mode, feat}), 32'({opmode_pkg::MODE_PROT, 1'b1}));
    pulse(EWR);
    chk(32'(emul), 32'h0000_0001);
    s_view();
    ctx <= 32'hcafe_0001;
    pulse(MSG);
    cyc(1);
    chk_entry();
    // A second request inside management mode must not save again.
    pulse(MSG);
    cyc(1);
    chk(32'(saved), 32'h0000_0000);
    s_resume(opmode_pkg::MODE_PROT, 1'b1);
    pulse(LEAVE);
    bnd <= 0;
    ctx <= 32'h0bad_f00d;
    pin_req <= 1;
    cyc(7);
    chk(32'(mode), 32'(opmode_pkg::MODE_REAL));
    bnd <= 1;
    cyc(1);
    chk_entry();
    pin_req <= 0;
    s_resume(opmode_pkg::MODE_REAL, 1'b0);
    ctx <= 32'h0000_5a5a;
    pulse(SWM);
    chk_entry();
    s_resume(opmode_pkg::MODE_REAL, 1'b0);
    pulse(ENTER);
    // Software entry from protected mode with an immediate return.
    pulse(SWM);
    s_resume(opmode_pkg::MODE_PROT, 1'b0);
    cyc(1);
    // A reset in mid-run from protected mode must land in real mode.
    nrst <= 0;
    cyc(1);
    chk(32'({mode, feat, saved, rest}), 32'h0000_0000);
    chk(rctx, 32'h0000_0000);
    nrst <= 1;
    cyc(1);
    chk(32'(mode), 32'(opmode_pkg::MODE_REAL));
    finish_test();
  end
endmodule

`default_nettype wire
